// ---- fmepr_params.svh ----
`ifndef FMEPR_PARAMS_SVH
`define FMEPR_PARAMS_SVH

`define FMEPR_ENTRY_ADDR 32'hFFA10084
`define FMEPR_PROT_ADDR 32'hFFA10088
`define FMEPR_INIT_ADDR 32'hFFA1008C
`define FMEPR_STAT_ADDR 32'hFFA100A0

`define FMEPR_KEY_ENTRY 8'hAA
`define FMEPR_KEY_PROT 8'h55
`define FMEPR_KEY_INIT 8'h2D

`define FMEPR_ENTRY_RST 16'h0000
`define FMEPR_ENTRY_CODE 16'h0001
`define FMEPR_ENTRY_DATA 16'h0080
`define FMEPR_PROT_RST 16'h0000

`define FMEPR_BIT_DATA 7
`define FMEPR_BIT_CODE 0
`define FMEPR_BIT_PCN 0
`define FMEPR_BIT_INIT 0
`define FMEPR_BIT_RDY 15
`define FMEPR_BIT_ERR 14
`define FMEPR_BIT_LOCK 0

`define FMEPR_RESP_OKAY 2'h0
`define FMEPR_RESP_SLVERR 2'h2

`endif

// ---- fmepr_pkg.sv ----
package fmepr_pkg;

   typedef enum logic [1:0] {
      FMEPR_W_IDLE,
      FMEPR_W_RESP
   } fmepr_wstate_t;

   typedef enum logic {
      FMEPR_R_IDLE,
      FMEPR_R_DATA
   } fmepr_rstate_t;

endpackage

// ---- fmepr_regs.sv ----
`timescale 1ns/1ps
`include "fmepr_params.svh"

module fmepr_regs (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sequencer_ready_flag,
   input wire logic forced_stop_start,
   output logic data_flash_pe_select,
   output logic code_flash_pe_select,
   output logic protect_cancel,
   output logic illegal_setting_error,
   output logic command_locked,
   output logic command_accept_ok
);

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------

   function automatic logic half_ok(input logic [3:0] strb);
      half_ok = (strb == 4'h3);
   endfunction

   function automatic logic same_word(input logic [31:0] a, input logic [31:0] b);
      same_word = (a[31:2] == b[31:2]);
   endfunction

   function automatic logic entry_legal(input logic [15:0] v);
      entry_legal = (v == `FMEPR_ENTRY_RST) || (v == `FMEPR_ENTRY_CODE)
         || (v == `FMEPR_ENTRY_DATA);
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------

   fmepr_pkg::fmepr_wstate_t wstate_r;
   fmepr_pkg::fmepr_rstate_t rstate_r;
   logic aw_held_r;
   logic w_held_r;
   logic [31:0] awaddr_r;
   logic [15:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic entry_data_r;
   logic entry_code_r;
   logic prot_cancel_r;
   logic err_r;
   logic lock_r;
   logic ready_s1_r;
   logic ready_s2_r;

   logic do_write;
   logic hit_entry;
   logic hit_prot;
   logic hit_init;
   logic hit_stat;
   logic wr_size_ok;
   logic [7:0] wkey;
   logic init_fire;
   logic entry_wr;
   logic prot_wr;
   logic [15:0] entry_val;
   logic entry_zero;
   logic ar_take;
   logic [15:0] rd_half;
   logic rd_hit;

   // ---------------------------------------------------------------
   // Ready flag synchroniser
   // ---------------------------------------------------------------

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ready_s1_r <= 1'b0;
         ready_s2_r <= 1'b0;
      end else begin
         ready_s1_r <= sequencer_ready_flag;
         ready_s2_r <= ready_s1_r;
      end
   end

   // ---------------------------------------------------------------
   // Write channel capture
   // ---------------------------------------------------------------

   assign s_axi_awready = !aw_held_r && (wstate_r == fmepr_pkg::FMEPR_W_IDLE);
   assign s_axi_wready = !w_held_r && (wstate_r == fmepr_pkg::FMEPR_W_IDLE);
   assign do_write = aw_held_r && w_held_r && (wstate_r == fmepr_pkg::FMEPR_W_IDLE);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         awaddr_r <= 32'h00000000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         wdata_r <= 16'h0000;
         wstrb_r <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata[15:0];
         wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Write decode
   // ---------------------------------------------------------------

   assign hit_entry = same_word(awaddr_r, `FMEPR_ENTRY_ADDR);
   assign hit_prot = same_word(awaddr_r, `FMEPR_PROT_ADDR);
   assign hit_init = same_word(awaddr_r, `FMEPR_INIT_ADDR);
   assign hit_stat = same_word(awaddr_r, `FMEPR_STAT_ADDR);
   assign wr_size_ok = half_ok(wstrb_r);
   // Key taken from this very write only
   assign wkey = wdata_r[15:8];
   assign init_fire = do_write && hit_init && wr_size_ok && ready_s2_r
      && (wkey == `FMEPR_KEY_INIT) && wdata_r[`FMEPR_BIT_INIT];
   assign entry_wr = do_write && hit_entry && wr_size_ok && ready_s2_r;
   assign prot_wr = do_write && hit_prot && wr_size_ok;
   assign entry_val = {8'h00, entry_data_r, 6'h00, entry_code_r};
   assign entry_zero = (entry_val == `FMEPR_ENTRY_RST);

   // ---------------------------------------------------------------
   // Write response
   // ---------------------------------------------------------------

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wstate_r <= fmepr_pkg::FMEPR_W_IDLE;
         bresp_r <= `FMEPR_RESP_OKAY;
      end else begin
         case (wstate_r)
            fmepr_pkg::FMEPR_W_IDLE: begin
               if (do_write) begin
                  wstate_r <= fmepr_pkg::FMEPR_W_RESP;
                  if ((hit_entry || hit_prot || hit_init) && wr_size_ok) begin
                     bresp_r <= `FMEPR_RESP_OKAY;
                  end else begin
                     bresp_r <= `FMEPR_RESP_SLVERR;
                  end
               end
            end
            fmepr_pkg::FMEPR_W_RESP: begin
               if (s_axi_bready) begin
                  wstate_r <= fmepr_pkg::FMEPR_W_IDLE;
               end
            end
            default: begin
               wstate_r <= fmepr_pkg::FMEPR_W_IDLE;
            end
         endcase
      end
   end

   assign s_axi_bvalid = (wstate_r == fmepr_pkg::FMEPR_W_RESP);
   assign s_axi_bresp = bresp_r;

   // ---------------------------------------------------------------
   // Mode entry bits
   // ---------------------------------------------------------------

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         entry_data_r <= 1'b0;
         entry_code_r <= 1'b0;
      end else if (init_fire) begin
         entry_data_r <= 1'b0;
         entry_code_r <= 1'b0;
      end else if (entry_wr) begin
         if (wkey != `FMEPR_KEY_ENTRY) begin
            entry_data_r <= 1'b0;
            entry_code_r <= 1'b0;
         end else if (!entry_zero) begin
            // Switching flash must pass through zero
            entry_data_r <= 1'b0;
            entry_code_r <= 1'b0;
         end else begin
            entry_data_r <= wdata_r[`FMEPR_BIT_DATA];
            entry_code_r <= wdata_r[`FMEPR_BIT_CODE];
         end
      end
   end

   // ---------------------------------------------------------------
   // Protect cancel bit
   // ---------------------------------------------------------------

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prot_cancel_r <= 1'b0;
      end else if (init_fire) begin
         prot_cancel_r <= 1'b0;
      end else if (entry_zero) begin
         prot_cancel_r <= 1'b0;
      end else if (prot_wr) begin
         if (wkey != `FMEPR_KEY_PROT) begin
            prot_cancel_r <= 1'b0;
         end else begin
            prot_cancel_r <= wdata_r[`FMEPR_BIT_PCN];
         end
      end
   end

   // ---------------------------------------------------------------
   // Illegal setting error and command lock
   // ---------------------------------------------------------------

   // Detection wins over a simultaneous forced stop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_r <= 1'b0;
      end else if (!entry_legal(entry_val)) begin
         err_r <= 1'b1;
      end else if (forced_stop_start) begin
         err_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_r <= 1'b0;
      end else if (!entry_legal(entry_val)) begin
         lock_r <= 1'b1;
      end else if (forced_stop_start) begin
         lock_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------

   assign s_axi_arready = (rstate_r == fmepr_pkg::FMEPR_R_IDLE);
   assign ar_take = s_axi_arvalid && s_axi_arready;

   always_comb begin
      rd_half = 16'h0000;
      rd_hit = 1'b1;
      if (same_word(s_axi_araddr, `FMEPR_ENTRY_ADDR)) begin
         rd_half = entry_val;
      end else if (same_word(s_axi_araddr, `FMEPR_PROT_ADDR)) begin
         rd_half[`FMEPR_BIT_PCN] = prot_cancel_r;
      end else if (same_word(s_axi_araddr, `FMEPR_INIT_ADDR)) begin
         rd_half = 16'h0000;
      end else if (same_word(s_axi_araddr, `FMEPR_STAT_ADDR)) begin
         rd_half[`FMEPR_BIT_RDY] = ready_s2_r;
         rd_half[`FMEPR_BIT_ERR] = err_r;
         rd_half[`FMEPR_BIT_LOCK] = lock_r;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rstate_r <= fmepr_pkg::FMEPR_R_IDLE;
      end else begin
         case (rstate_r)
            fmepr_pkg::FMEPR_R_IDLE: begin
               if (ar_take) begin
                  rstate_r <= fmepr_pkg::FMEPR_R_DATA;
               end
            end
            fmepr_pkg::FMEPR_R_DATA: begin
               if (s_axi_rready) begin
                  rstate_r <= fmepr_pkg::FMEPR_R_IDLE;
               end
            end
            default: begin
               rstate_r <= fmepr_pkg::FMEPR_R_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_r <= 32'h00000000;
         rresp_r <= `FMEPR_RESP_OKAY;
      end else if (ar_take) begin
         rdata_r <= {16'h0000, rd_half};
         rresp_r <= rd_hit ? `FMEPR_RESP_OKAY : `FMEPR_RESP_SLVERR;
      end
   end

   assign s_axi_rvalid = (rstate_r == fmepr_pkg::FMEPR_R_DATA);
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // ---------------------------------------------------------------
   // Outputs to the sequencer
   // ---------------------------------------------------------------

   assign data_flash_pe_select = entry_data_r;
   assign code_flash_pe_select = entry_code_r;
   assign protect_cancel = prot_cancel_r;
   assign illegal_setting_error = err_r;
   assign command_locked = lock_r;
   assign command_accept_ok = (entry_data_r ^ entry_code_r) && !lock_r;

endmodule // fmepr_regs

// ---- fmepr_regs_assertions.sv ----
`timescale 1ns/1ps
// ----
// Port checks
// ----
module fmepr_regs_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic forced_stop_start,
   input wire logic data_flash_pe_select,
   input wire logic code_flash_pe_select,
   input wire logic protect_cancel,
   input wire logic illegal_setting_error,
   input wire logic command_locked,
   input wire logic command_accept_ok
);
   wire logic d = data_flash_pe_select;
   wire logic c = code_flash_pe_select;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   illegal_flag_a: assert property (d && c |=> illegal_setting_error)
      else $error("illegal entry not flagged");
   lock_pair_a: assert property (command_locked == illegal_setting_error)
      else $error("lock differs from error");
   accept_ok_a: assert property (command_accept_ok == ((d ^ c) && !command_locked))
      else $error("command accept wrong");
   select_rise_a: assert property ($rose(d) || $rose(c) |-> $past(!d && !c) && $rose(s_axi_bvalid))
      else $error("select set from nonzero");
   protect_rise_a: assert property ($rose(protect_cancel) |-> (d || c) && $rose(s_axi_bvalid))
      else $error("protect set while entry zero");
   protect_zero_a: assert property (!d && !c |=> !protect_cancel)
      else $error("protect not forced low");
   stop_clear_a: assert property (forced_stop_start && !(d && c) |=> !illegal_setting_error)
      else $error("forced stop left error");
   cover property (d && !c);
   cover property (protect_cancel);
   cover property (illegal_setting_error);
endmodule // fmepr_regs_chk

bind fmepr_regs fmepr_regs_chk i_fmepr_regs_chk (.*);

// ---- fmepr_regs_tb.sv ----
`timescale 1ns/1ps
`include "fmepr_params.svh"
module fmepr_regs_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic sequencer_ready_flag = 1'b1, forced_stop_start = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic data_flash_pe_select, code_flash_pe_select, protect_cancel;
   logic illegal_setting_error, command_locked, command_accept_ok;
   int fail_count = 0;
   int n_tests = 0;
   localparam logic [31:0] E = `FMEPR_ENTRY_ADDR;
   localparam logic [31:0] P = `FMEPR_PROT_ADDR;
   localparam logic [31:0] I = `FMEPR_INIT_ADDR;
   localparam logic [1:0] OK = `FMEPR_RESP_OKAY;
   localparam logic [1:0] SE = `FMEPR_RESP_SLVERR;
   always #25 aclk = ~aclk;
   fmepr_regs i_fmepr_regs (.*);
   // ----
   // Bus tasks
   // ----
   task automatic ck(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) begin
         fail_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic wc(input logic [31:0] a, input logic [15:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(ta && tw)) begin
         @(negedge aclk);
         ta = ta | (s_axi_awvalid & s_axi_awready);
         tw = tw | (s_axi_wvalid & s_axi_wready);
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      ck(s_axi_bresp, er);
   endtask
   task automatic rc(input logic [31:0] a, input logic [31:0] x, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      ck(s_axi_rdata, x);
      ck(s_axi_rresp, er);
   endtask
   task automatic ew(input logic [15:0] d, input logic [31:0] x);
      wc(E, d, 4'h3, OK);
      rc(E, x, OK);
   endtask
   task automatic pw(input logic [15:0] d, input logic [31:0] x);
      wc(P, d, 4'h3, OK);
      rc(P, x, OK);
   endtask
   task automatic sp;
      @(posedge aclk) forced_stop_start <= 1'b1;
      @(posedge aclk) forced_stop_start <= 1'b0;
      repeat (2) @(negedge aclk);
   endtask
   task automatic complete_run;
      $display("fail_count %0d n_tests %0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      complete_run;
   end
   // ----
   // Tests
   // ----
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rc(E, 0, OK);
      rc(P, 0, OK);
      pw(16'h5501, 0);
      ew(16'h5580, 0);
      ew(16'hAA80, 32'h80);
      ck(data_flash_pe_select, 1);
      ck(command_accept_ok, 1);
      ew(16'hAA01, 0);
      ew(16'hAA01, 1);
      ck(code_flash_pe_select, 1);
      ck(data_flash_pe_select, 0);
      pw(16'h5501, 1);
      ck(protect_cancel, 1);
      pw(16'h0001, 0);
      pw(16'h5501, 1);
      pw(16'h5500, 0);
      pw(16'h5501, 1);
      ew(16'hAA00, 0);
      rc(P, 0, OK);
      ew(16'hAA80, 32'h80);
      @(posedge aclk) sequencer_ready_flag <= 1'b0;
      repeat (3) @(posedge aclk);
      ew(16'h1100, 32'h80);
      ew(16'hAA00, 32'h80);
      @(posedge aclk) sequencer_ready_flag <= 1'b1;
      repeat (3) @(posedge aclk);
      ew(16'h1100, 0);
      ew(16'hAA01, 1);
      pw(16'h5501, 1);
      wc(I, 16'h2C01, 4'h3, OK);
      rc(E, 1, OK);
      wc(I, 16'h2D01, 4'h3, OK);
      rc(E, 0, OK);
      rc(P, 0, OK);
      ew(16'hAA00, 0);
      ew(16'h0080, 0);
      wc(E, 16'hAA80, 4'hF, SE);
      rc(E, 0, OK);
      wc(E + 32'h0C, 16'hAA80, 4'h3, SE);
      rc(E + 32'h0C, 0, SE);
      ew(16'hAA81, 32'h81);
      repeat (2) @(negedge aclk);
      ck(illegal_setting_error, 1);
      ck(command_locked, 1);
      ck(command_accept_ok, 0);
      rc(`FMEPR_STAT_ADDR, 32'hC001, OK);
      sp;
      ck(illegal_setting_error, 1);
      ew(16'hAA00, 0);
      sp;
      ck(illegal_setting_error, 0);
      ck(command_locked, 0);
      complete_run;
   end
endmodule // fmepr_regs_tb
